// ---- hwc_pkg.sv ----
// package for the hardware configuration register block
package hwc_pkg;
  localparam logic [7:0] HWC_ADDR_CFG = 8'h14;
  localparam int HWC_BIT_EMUL = 16;
  localparam int HWC_BIT_PROT = 15;
  localparam int HWC_BIT_BIR = 12;
  localparam int HWC_BIT_LED = 11;
  localparam int HWC_BIT_SHIFT_LO = 9;
  localparam int HWC_BIT_SBP = 8;
  localparam int HWC_BIT_MII = 7;
  localparam int HWC_BIT_DRP = 6;
  localparam int HWC_BIT_MEF = 5;
  localparam int HWC_BIT_ETC = 4;
  localparam int HWC_BIT_LITE_SOFT_RESET = 3;
  localparam int HWC_BIT_PSEL = 2;
  localparam int HWC_BIT_BCE = 1;
  localparam int HWC_BIT_FULL_SOFT_RESET = 0;
  localparam logic [31:0] HWC_WRITE_MASK = 32'h0001_9FF2;
  localparam int HWC_CLK_MHZ = 100;
  localparam int HWC_LED_NORMAL_MS = 80;
  localparam int HWC_LED_FAST_NS = 15000;
  localparam int HWC_PROM_TO_MS = 30;
  localparam int HWC_PROM_TO_FAST_NS = 1280;
  localparam int HWC_LED_NORMAL_CYC = HWC_LED_NORMAL_MS * 1000 * HWC_CLK_MHZ;
  localparam int HWC_LED_FAST_CYC = HWC_LED_FAST_NS * HWC_CLK_MHZ / 1000;
  localparam int HWC_PROM_TO_CYC = HWC_PROM_TO_MS * 1000 * HWC_CLK_MHZ;
  localparam int HWC_PROM_TO_FAST_CYC = HWC_PROM_TO_FAST_NS * HWC_CLK_MHZ / 1000;
  localparam int HWC_LITE_SEQ_CYC = 16;
  localparam int HWC_FULL_SEQ_CYC = 64;
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } hwc_bus_req_t;
  typedef enum logic [1:0] {HWC_IDLE = 2'b00, HWC_LITE = 2'b01, HWC_FULL = 2'b11} hwc_state_t;
endpackage

// ---- hwc_hardware_configuration_register.sv ----
// hardware configuration register with reset sequencing and control decodes
// Operation
// - emulation bit picks descriptor source without prom
// - protect bit shields fields from soft resets
// - empty bulk-in answers zlp or nak
// - led fast bit shortens blink to 15us
// - two-bit field shifts receive data start
// - loss of sync stalls bulk-out unless disabled
// - mii bit drives pins out in internal mode
// - mii bit ignored externally, overrides gpio
// - discard bit drops errored received frames
// - packing bit allows multi-frame transmit packets
// - prom timeout 30ms or 1.28us
// - lite reset spares usb controller, prom, phy
// - lite reset bit self-clears when done
// - phy select bit follows pin default
// - burst enable makes burst cap register apply
// - full reset resets ext phy if selected, reloads prom
// - usb phy disconnected during full reset
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module hwc_hardware_configuration_register
  import hwc_pkg::*;
#(
  parameter int LED_NORMAL_CYC = HWC_LED_NORMAL_CYC,
  parameter int PROM_TO_CYC = HWC_PROM_TO_CYC
)(
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst,
  // register port
  input wire hwc_bus_req_t bus_req,
  output logic [31:0] rdata,
  // straps and status from the device
  input wire logic phy_choice_pin,
  input wire logic prom_present,
  input wire logic rx_fifo_empty,
  input wire logic sync_lost,
  input wire logic prom_waiting,
  // control outputs
  output logic use_descriptor_ram,
  output logic bulk_in_nak,
  output logic bulk_in_zlp,
  output logic activity_led_tick,
  output logic [1:0] receive_data_shift,
  output logic bulk_out_stall,
  output logic mii_out_enable,
  output logic mii_gpio_block,
  output logic discard_bad_frames,
  output logic multi_frame_packing,
  output logic prom_timeout,
  output logic burst_limit_enable,
  // reset sequencing outputs
  output logic lite_reset_active,
  output logic full_reset_active,
  output logic ext_phy_reset,
  output logic prom_reload,
  output logic usb_phy_disconnect
);
  logic [31:0] cfg_q;
  logic psel_q;
  logic psel_taken_q;
  hwc_state_t state_q;
  logic [6:0] seq_cnt_q;
  logic [31:0] led_cnt_q;
  logic [31:0] to_cnt_q;
  logic soft_rst;
  logic wr_cfg;
  logic [31:0] led_limit;
  logic [31:0] to_limit;

  assign wr_cfg = bus_req.wr && bus_req.addr == {24'h00_0000, HWC_ADDR_CFG};
  // soft resets reuse the sequencer; the register itself only sees rst as power-on
  assign soft_rst = state_q != HWC_IDLE && seq_cnt_q == 7'h00;

  // strap tracks the pin under reset, frozen at the first edge after release
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      psel_taken_q <= 1'b0;
      psel_q <= phy_choice_pin;
    end
    else if (!psel_taken_q)
    begin
      psel_taken_q <= 1'b1;
      psel_q <= phy_choice_pin;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      cfg_q <= 32'h0000_0000;
    else if (soft_rst)
    begin
      // protected fields survive a soft reset while protection is on
      if (cfg_q[HWC_BIT_PROT])
        cfg_q <= cfg_q & 32'h0001_8000;
      else
        cfg_q <= 32'h0000_0000;
    end
    else if (wr_cfg)
      cfg_q <= bus_req.wdata & HWC_WRITE_MASK;
  end

  // reset sequencer; triggers written while busy are ignored
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state_q <= HWC_IDLE;
      seq_cnt_q <= 7'h00;
    end
    else
    begin
      unique case (state_q)
        HWC_IDLE:
        begin
          seq_cnt_q <= 7'h00;
          if (wr_cfg && bus_req.wdata[HWC_BIT_FULL_SOFT_RESET])
            state_q <= HWC_FULL;
          else if (wr_cfg && bus_req.wdata[HWC_BIT_LITE_SOFT_RESET])
            state_q <= HWC_LITE;
        end
        HWC_LITE:
        begin
          seq_cnt_q <= seq_cnt_q + 7'h01;
          if (seq_cnt_q == 7'(HWC_LITE_SEQ_CYC - 1))
            state_q <= HWC_IDLE;
        end
        HWC_FULL:
        begin
          seq_cnt_q <= seq_cnt_q + 7'h01;
          if (seq_cnt_q == 7'(HWC_FULL_SEQ_CYC - 1))
            state_q <= HWC_IDLE;
        end
        default:
          state_q <= HWC_IDLE;
      endcase
    end
  end

  assign lite_reset_active = state_q == HWC_LITE;
  assign full_reset_active = state_q == HWC_FULL;
  assign usb_phy_disconnect = full_reset_active;
  assign ext_phy_reset = full_reset_active && psel_q;
  assign prom_reload = full_reset_active && seq_cnt_q == 7'h00;

  always_ff @(posedge mclk)
  begin
    if (rst)
      rdata <= 32'h0000_0000;
    else if (bus_req.rd && bus_req.addr == {24'h00_0000, HWC_ADDR_CFG})
    begin
      rdata <= cfg_q;
      rdata[HWC_BIT_PSEL] <= psel_q;
      rdata[HWC_BIT_LITE_SOFT_RESET] <= lite_reset_active;
      rdata[HWC_BIT_FULL_SOFT_RESET] <= full_reset_active;
    end
    else
      rdata <= 32'h0000_0000;
  end

  assign use_descriptor_ram = !prom_present && cfg_q[HWC_BIT_EMUL];
  assign bulk_in_nak = rx_fifo_empty && cfg_q[HWC_BIT_BIR];
  assign bulk_in_zlp = rx_fifo_empty && !cfg_q[HWC_BIT_BIR];
  assign receive_data_shift = cfg_q[HWC_BIT_SHIFT_LO +: 2];
  assign bulk_out_stall = sync_lost && !cfg_q[HWC_BIT_SBP];
  assign mii_out_enable = !psel_q && cfg_q[HWC_BIT_MII];
  assign mii_gpio_block = mii_out_enable;
  assign discard_bad_frames = cfg_q[HWC_BIT_DRP];
  assign multi_frame_packing = cfg_q[HWC_BIT_MEF];
  assign burst_limit_enable = cfg_q[HWC_BIT_BCE];

  // activity led half-period tick
  assign led_limit = cfg_q[HWC_BIT_LED] ? 32'(HWC_LED_FAST_CYC) : 32'(LED_NORMAL_CYC);
  always_ff @(posedge mclk)
  begin
    if (rst || led_cnt_q >= led_limit - 32'h0000_0001)
      led_cnt_q <= 32'h0000_0000;
    else
      led_cnt_q <= led_cnt_q + 32'h0000_0001;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      activity_led_tick <= 1'b0;
    else
      activity_led_tick <= led_cnt_q >= led_limit - 32'h0000_0001;
  end

  // prom response watchdog; counts only while a response is awaited
  assign to_limit = cfg_q[HWC_BIT_ETC] ? 32'(HWC_PROM_TO_FAST_CYC) : 32'(PROM_TO_CYC);
  always_ff @(posedge mclk)
  begin
    if (rst || !prom_waiting)
      to_cnt_q <= 32'h0000_0000;
    else if (to_cnt_q < to_limit)
      to_cnt_q <= to_cnt_q + 32'h0000_0001;
  end
  always_ff @(posedge mclk)
  begin
    if (rst)
      prom_timeout <= 1'b0;
    else
      prom_timeout <= prom_waiting && to_cnt_q >= to_limit - 32'h0000_0001;
  end

  a_lite_self_clear: assert property (@(posedge mclk) disable iff (rst)
    $rose(lite_reset_active) |-> ##16 !lite_reset_active)
    else $error("lite reset did not clear");
  a_full_disconnect: assert property (@(posedge mclk) disable iff (rst)
    $rose(full_reset_active) |-> usb_phy_disconnect [*8])
    else $error("usb phy not disconnected");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    (rdata[31:17] == 15'h0000) && (rdata[14:13] == 2'b00))
    else $error("reserved bits nonzero");
  a_stall_select: assert property (@(posedge mclk) disable iff (rst)
    sync_lost |-> bulk_out_stall == !cfg_q[HWC_BIT_SBP])
    else $error("bulk out stall wrong");
  a_bulk_reply: assert property (@(posedge mclk) disable iff (rst)
    rx_fifo_empty |-> bulk_in_nak != bulk_in_zlp)
    else $error("bulk in reply wrong");
  a_emul_select: assert property (@(posedge mclk) disable iff (rst)
    prom_present |-> !use_descriptor_ram)
    else $error("emulation used with prom");
  a_protect_keep: assert property (@(posedge mclk) disable iff (rst)
    soft_rst && cfg_q[HWC_BIT_PROT] |=> cfg_q[HWC_BIT_PROT])
    else $error("protect lost on soft reset");
  a_mii_external: assert property (@(posedge mclk) disable iff (rst)
    psel_q |-> !mii_out_enable && !mii_gpio_block)
    else $error("mii active with external phy");

  // a trigger write still lands before the sequence clears the fields
  sequence s_idle_write;
    wr_cfg && state_q == HWC_IDLE;
  endsequence
  sequence s_full_start;
    $rose(full_reset_active);
  endsequence
  sequence s_lite_start;
    $rose(lite_reset_active);
  endsequence

  a_full_self_clear: assert property (@(posedge mclk) disable iff (rst)
    s_full_start |-> ##64 !full_reset_active)
    else $error("full reset did not clear");
  a_full_reload: assert property (@(posedge mclk) disable iff (rst)
    s_full_start |-> prom_reload ##1 !prom_reload)
    else $error("prom reload pulse wrong");
  a_full_ext_phy: assert property (@(posedge mclk) disable iff (rst)
    full_reset_active |-> ext_phy_reset == psel_q)
    else $error("external phy reset wrong");
  a_lite_spares: assert property (@(posedge mclk) disable iff (rst)
    s_lite_start |-> (!usb_phy_disconnect && !prom_reload && !ext_phy_reset) [*8])
    else $error("lite reset touched usb or prom");

  // field writes from an idle sequencer show up one edge later
  a_shift_write: assert property (@(posedge mclk) disable iff (rst)
    s_idle_write |=> receive_data_shift == $past(bus_req.wdata[10:9]))
    else $error("receive shift not written");
  a_drop_write: assert property (@(posedge mclk) disable iff (rst)
    s_idle_write |=> discard_bad_frames == $past(bus_req.wdata[6]))
    else $error("discard bit not written");
  a_pack_write: assert property (@(posedge mclk) disable iff (rst)
    s_idle_write |=> multi_frame_packing == $past(bus_req.wdata[5]))
    else $error("packing bit not written");
  a_burst_write: assert property (@(posedge mclk) disable iff (rst)
    s_idle_write |=> burst_limit_enable == $past(bus_req.wdata[1]))
    else $error("burst bit not written");
  a_reserved_write: assert property (@(posedge mclk) disable iff (rst)
    s_idle_write |=> cfg_q[31:17] == 15'h0000 && cfg_q[14:13] == 2'b00)
    else $error("reserved bits stored");

  // soft reset keeps only the protected pair
  a_soft_clear: assert property (@(posedge mclk) disable iff (rst)
    soft_rst && !cfg_q[HWC_BIT_PROT] |=> cfg_q == 32'h0000_0000)
    else $error("soft reset left fields");
  a_protect_emul: assert property (@(posedge mclk) disable iff (rst)
    soft_rst && cfg_q[HWC_BIT_PROT] |=> cfg_q[HWC_BIT_EMUL] == $past(cfg_q[HWC_BIT_EMUL]))
    else $error("emulation bit lost");

  a_led_single: assert property (@(posedge mclk) disable iff (rst)
    activity_led_tick |=> !activity_led_tick)
    else $error("led tick too long");
  a_prom_idle: assert property (@(posedge mclk) disable iff (rst)
    !prom_waiting |=> !prom_timeout)
    else $error("timeout without wait");
  a_mii_internal: assert property (@(posedge mclk) disable iff (rst)
    !psel_q && cfg_q[HWC_BIT_MII] |-> mii_out_enable && mii_gpio_block)
    else $error("mii pins not driven");
  a_psel_read: assert property (@(posedge mclk) disable iff (rst)
    bus_req.rd && bus_req.addr == {24'h00_0000, HWC_ADDR_CFG} |=> rdata[HWC_BIT_PSEL] == $past(psel_q))
    else $error("phy select readback wrong");
  a_bulk_quiet: assert property (@(posedge mclk) disable iff (rst)
    !rx_fifo_empty |-> !bulk_in_nak && !bulk_in_zlp)
    else $error("bulk in reply without empty");
  a_stall_quiet: assert property (@(posedge mclk) disable iff (rst)
    !sync_lost |-> !bulk_out_stall)
    else $error("stall without sync loss");
endmodule
`default_nettype wire

// ---- tb_hardware_configuration_register.sv ----
// self-checking testbench for the hardware configuration register
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_hardware_configuration_register;
  import hwc_pkg::*;
  localparam logic [31:0] CFG = 32'h0000_0014;
  logic mclk, rst, phy_choice_pin, prom_present, rx_fifo_empty, sync_lost, prom_waiting;
  hwc_bus_req_t req;
  logic [31:0] rdata;
  logic [1:0] shift;
  logic desc_ram, nak, zlp, tick, stall, mii_oe, mii_blk, drop, pack, to, burst, lite, full, ephy, reload, disc;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  hwc_hardware_configuration_register #(.LED_NORMAL_CYC(100), .PROM_TO_CYC(50)) dut_u (
    .mclk(mclk), .rst(rst), .bus_req(req), .rdata(rdata), .phy_choice_pin(phy_choice_pin),
    .prom_present(prom_present), .rx_fifo_empty(rx_fifo_empty), .sync_lost(sync_lost),
    .prom_waiting(prom_waiting), .use_descriptor_ram(desc_ram), .bulk_in_nak(nak), .bulk_in_zlp(zlp),
    .activity_led_tick(tick), .receive_data_shift(shift), .bulk_out_stall(stall), .mii_out_enable(mii_oe),
    .mii_gpio_block(mii_blk), .discard_bad_frames(drop), .multi_frame_packing(pack), .prom_timeout(to),
    .burst_limit_enable(burst), .lite_reset_active(lite), .full_reset_active(full), .ext_phy_reset(ephy),
    .prom_reload(reload), .usb_phy_disconnect(disc));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic wrap_up;
    if (bad_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // a hang counts against the run
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 10000)
    begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    @(negedge mclk);
    `CHK(rdata, e)
  endtask
  task automatic do_reset(input logic strap);
    @(posedge mclk);
    rst <= 1'b1;
    phy_choice_pin <= strap;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
  endtask
  // sequence length seen from its first cycle
  task automatic seq_len(output int c);
    c = 0;
    while ((lite || full) && c < 200)
    begin
      c++;
      @(negedge mclk);
    end
  endtask
  task automatic prom_wait(input int lo, input int hi);
    @(posedge mclk);
    prom_waiting <= 1'b1;
    repeat (lo) @(negedge mclk);
    `CHK(to, 1'b0)
    repeat (hi - lo) @(negedge mclk);
    `CHK(to, 1'b1)
    @(posedge mclk);
    prom_waiting <= 1'b0;
  endtask
  initial
  begin
    req = '0;
    rst = 1'b1;
    phy_choice_pin = 1'b1;
    prom_present = 1'b0;
    rx_fifo_empty = 1'b1;
    sync_lost = 1'b1;
    prom_waiting = 1'b0;
    do_reset(1'b1);
    rd(CFG, 32'h0000_0004);
    `CHK({zlp, nak, stall, desc_ram}, 4'b1010)
    wr(CFG, 32'hFFFF_FFF6);
    rd(CFG, 32'h0001_9FF6);
    `CHK({zlp, nak, stall, desc_ram}, 4'b0101)
    `CHK({shift, drop, pack, burst}, 5'b11111)
    `CHK({mii_oe, mii_blk}, 2'b00)
    @(posedge mclk);
    prom_present <= 1'b1;
    @(negedge mclk);
    `CHK(desc_ram, 1'b0)
    wr(32'h0000_0018, 32'h0000_0000);
    rd(32'h0000_0018, 32'h0000_0000);
    rd(CFG, 32'h0001_9FF6);
    prom_wait(120, 135);
    n = 0;
    repeat (300) @(negedge mclk) n += tick;
    `CHK(n <= 1, 1'b1)
    wr(CFG, 32'h0001_8000);
    prom_wait(45, 55);
    n = 0;
    repeat (1000) @(negedge mclk) n += tick;
    `CHK(n >= 9 && n <= 11, 1'b1)
    // lite reset with protection set keeps bits 16 and 15
    wr(CFG, 32'h0001_8208);
    `CHK({lite, disc, reload}, 3'b100)
    seq_len(n);
    `CHK(n, HWC_LITE_SEQ_CYC)
    rd(CFG, 32'h0001_8004);
    wr(CFG, 32'h0001_0001);
    `CHK({full, disc, ephy, reload}, 4'b1111)
    seq_len(n);
    `CHK(n, HWC_FULL_SEQ_CYC)
    `CHK({disc, ephy}, 2'b00)
    rd(CFG, 32'h0000_0004);
    do_reset(1'b0);
    rd(CFG, 32'h0000_0000);
    wr(CFG, 32'h0000_0080);
    `CHK({mii_oe, mii_blk}, 2'b11)
    wr(CFG, 32'h0000_0001);
    `CHK({full, disc, ephy}, 3'b110)
    seq_len(n);
    `CHK(mii_oe, 1'b0)
    wrap_up();
  end
endmodule
`default_nettype wire
